// ==== rtl/tec_timer.sv ====
// tec_timer.sv: 8-bit timer/event counter 0 with pin input filters and avalon-mm slave
// assumes: all pins synchronous-sampled on mclk_i, one avalon master, byte data in low lane
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`include "tec_cfg.svh"

module tec_timer #(
   parameter int FILT_SAMPLES = `TEC_FILT_SAMPLES,
   parameter int NUM_TIMERS   = 4,
   parameter int NUM_EXT_IRQ  = 2
) (
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [3:0]  timer_pin_i,
   input  wire logic [1:0]  ext_irq_pin_i,
   output logic      [5:0]  pin_level_o,
   output logic             timer_irq_o,
   output logic      [7:0]  timer_irq_vector_o,
   output logic             wake_up_o,
   output logic             power_down_o
);

   localparam int NPINS = NUM_TIMERS + NUM_EXT_IRQ;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (FILT_SAMPLES < 2 || FILT_SAMPLES > 256) begin : g_bad_filt
      $error("FILT_SAMPLES must lie in 2..256");
   end
   if (NUM_TIMERS != 4 || NUM_EXT_IRQ != 2) begin : g_bad_pins
      $error("filter register layout serves exactly 4 timers and 2 interrupt inputs");
   end

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic                      wait_reg;
   logic [31:0]               rdata_reg;
   logic [7:0]                preload_reg;
   logic [7:0]                count_reg;
   logic [7:0]                count_next;
   logic [7:0]                control_reg;
   logic [5:0]                filter_reg;
   logic                      int_enable_reg;
   logic                      int_flag_reg;
   logic                      power_down_reg;
   logic                      wake_reg;
   logic                      irq_reg;
   logic [7:0]                presc_reg;
   logic [7:0]                presc_mask;
   logic                      tick;
   logic                      pin_samp_reg;
   logic                      leading_edge;
   logic                      trailing_edge;
   logic                      pin_active;
   logic                      count_step;
   logic                      overflow;
   logic                      inhibit;
   logic                      bus_req;
   logic                      accept;
   logic                      wr_lo;
   logic                      pw_done;
   logic [NPINS-1:0]          pin_raw;
   logic [NPINS-1:0]          sync1_reg;
   logic [NPINS-1:0]          sync2_reg;
   logic [NPINS-1:0]          filt_reg;
   tec_pkg::tec_mode_t        mode;
   tec_pkg::tec_pw_state_t    pw_state_reg;
   tec_pkg::tec_pw_state_t    pw_state_next;

   assign pin_raw = {ext_irq_pin_i, timer_pin_i};
   assign mode    = tec_pkg::tec_mode_t'(control_reg[`TEC_CTL_MODE_HI:`TEC_CTL_MODE_LO]);

   // ----------------------------------------
   // avalon-mm slave: one wait cycle, then accept
   // ----------------------------------------
   assign bus_req = avs_read_i | avs_write_i;
   assign accept  = bus_req & ~wait_reg;
   assign wr_lo   = avs_write_i & accept & avs_byteenable_i[0];

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg <= 32'h0;
      end else if (avs_read_i && wait_reg) begin
         case (avs_address_i)
            `TEC_OFS_COUNT:   rdata_reg <= {24'h0, count_reg};
            `TEC_OFS_CONTROL: rdata_reg <= {24'h0, control_reg};
            `TEC_OFS_INTCTL:  rdata_reg <= {30'h0, int_flag_reg, int_enable_reg};
            `TEC_OFS_FILTER:  rdata_reg <= {26'h0, filter_reg};
            `TEC_OFS_POWER:   rdata_reg <= {31'h0, power_down_reg};
            default:          rdata_reg <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         filter_reg <= `TEC_RST_FILTER;
      end else if (wr_lo && avs_address_i == `TEC_OFS_FILTER) begin
         filter_reg <= avs_writedata_i[`TEC_FLT_USED-1:0];
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         control_reg <= `TEC_RST_CONTROL;
      end else if (wr_lo && avs_address_i == `TEC_OFS_CONTROL) begin
         control_reg <= avs_writedata_i[7:0];
      end else if (pw_done) begin
         control_reg[`TEC_CTL_RUN] <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         preload_reg <= `TEC_RST_COUNT;
      end else if (wr_lo && avs_address_i == `TEC_OFS_COUNT) begin
         preload_reg <= avs_writedata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_enable_reg <= 1'b0;
      end else if (wr_lo && avs_address_i == `TEC_OFS_INTCTL) begin
         int_enable_reg <= avs_writedata_i[`TEC_INT_ENABLE];
      end
   end

   // flag: overflow set wins over a software clear in the same cycle
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_flag_reg <= 1'b0;
      end else if (overflow) begin
         int_flag_reg <= 1'b1;
      end else if (wr_lo && avs_address_i == `TEC_OFS_INTCTL) begin
         int_flag_reg <= avs_writedata_i[`TEC_INT_FLAG];
      end
   end

   // power-down is left by a wake-up; software may also clear it
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         power_down_reg <= 1'b0;
      end else if (wr_lo && avs_address_i == `TEC_OFS_POWER) begin
         power_down_reg <= avs_writedata_i[`TEC_PWR_DOWN];
      end else if (overflow && !int_flag_reg) begin
         power_down_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // pin synchronisers and digital filters
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // each pin keeps its own level flop, so every bit has one driver
   for (genvar gi = 0; gi < NPINS; gi++) begin : g_filt
      logic [7:0] stable_reg;
      logic       level_reg;
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            stable_reg <= 8'h0;
            level_reg  <= 1'b0;
         end else if (!filter_reg[gi]) begin
            stable_reg <= 8'h0;
            level_reg  <= sync2_reg[gi];
         end else if (sync2_reg[gi] == level_reg) begin
            stable_reg <= 8'h0;
         end else if (stable_reg == 8'(FILT_SAMPLES - 1)) begin
            stable_reg <= 8'h0;
            level_reg  <= sync2_reg[gi];
         end else begin
            stable_reg <= stable_reg + 8'h1;
         end
      end
      assign filt_reg[gi] = level_reg;
   end

   // ----------------------------------------
   // prescaler and pin sampling at timer clock
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         presc_reg <= 8'h0;
      end else begin
         presc_reg <= presc_reg + 8'h1;
      end
   end

   assign presc_mask = 8'((9'h1 << control_reg[`TEC_CTL_PSC_HI:`TEC_CTL_PSC_LO]) - 9'h1);
   assign tick       = (presc_reg & presc_mask) == presc_mask;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_samp_reg <= 1'b0;
      end else if (tick) begin
         pin_samp_reg <= filt_reg[0];
      end
   end

   // edge select low: active level low, pulse starts on a falling edge
   assign pin_active    = filt_reg[0] ^ ~control_reg[`TEC_CTL_EDGE];
   assign leading_edge  = tick & (pin_samp_reg ^ filt_reg[0]) & pin_active;
   assign trailing_edge = tick & (pin_samp_reg ^ filt_reg[0]) & ~pin_active;

   // ----------------------------------------
   // pulse width measurement sequencing
   // ----------------------------------------
   always_comb begin
      pw_state_next = pw_state_reg;
      pw_done       = 1'b0;
      case (pw_state_reg)
         tec_pkg::TEC_PW_IDLE: begin
            if (control_reg[`TEC_CTL_RUN] && mode == tec_pkg::TEC_MODE_PULSE) begin
               pw_state_next = tec_pkg::TEC_PW_ARM;
            end
         end
         tec_pkg::TEC_PW_ARM: begin
            if (!control_reg[`TEC_CTL_RUN] || mode != tec_pkg::TEC_MODE_PULSE) begin
               pw_state_next = tec_pkg::TEC_PW_IDLE;
            end else if (leading_edge) begin
               pw_state_next = tec_pkg::TEC_PW_MEAS;
            end
         end
         tec_pkg::TEC_PW_MEAS: begin
            if (!control_reg[`TEC_CTL_RUN] || mode != tec_pkg::TEC_MODE_PULSE) begin
               pw_state_next = tec_pkg::TEC_PW_IDLE;
            end else if (trailing_edge) begin
               pw_state_next = tec_pkg::TEC_PW_IDLE;
               pw_done       = 1'b1;
            end
         end
         default: begin
            pw_state_next = tec_pkg::TEC_PW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pw_state_reg <= tec_pkg::TEC_PW_IDLE;
      end else begin
         pw_state_reg <= pw_state_next;
      end
   end

   // ----------------------------------------
   // counter
   // ----------------------------------------
   assign inhibit = (avs_read_i && avs_address_i == `TEC_OFS_COUNT) ||
                    (avs_write_i && avs_address_i == `TEC_OFS_COUNT);

   always_comb begin
      count_step = 1'b0;
      case (mode)
         tec_pkg::TEC_MODE_TIMER: count_step = tick;
         tec_pkg::TEC_MODE_EVENT: count_step = leading_edge;
         tec_pkg::TEC_MODE_PULSE: count_step = tick & pin_active & (pw_state_reg == tec_pkg::TEC_PW_MEAS);
         default:                 count_step = 1'b0;
      endcase
   end

   assign overflow   = control_reg[`TEC_CTL_RUN] & ~inhibit & count_step & (count_reg == 8'hff);
   assign count_next = overflow ? preload_reg : count_reg + 8'h1;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg <= `TEC_RST_COUNT;
      end else if (wr_lo && avs_address_i == `TEC_OFS_COUNT && !control_reg[`TEC_CTL_RUN]) begin
         count_reg <= avs_writedata_i[7:0];
      end else if (control_reg[`TEC_CTL_RUN] && count_step && !inhibit) begin
         count_reg <= count_next;
      end
   end

   // ----------------------------------------
   // interrupt and wake-up outputs
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         irq_reg  <= (int_flag_reg | overflow) & int_enable_reg;
         wake_reg <= overflow & power_down_reg & ~int_flag_reg;
      end
   end

   assign avs_readdata_o     = rdata_reg;
   assign avs_waitrequest_o  = wait_reg;
   assign pin_level_o        = filt_reg;
   assign timer_irq_o        = irq_reg;
   assign timer_irq_vector_o = `TEC_VECTOR_ADDR;
   assign wake_up_o          = wake_reg;
   assign power_down_o       = power_down_reg;

endmodule

// ==== rtl/tec_cfg.svh ====
// tec_cfg.svh: register map, field positions, reset values and timing counts
// assumes: not included by tec_pkg.sv; included by the timer/event counter design and its assertion checker
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TEC_OFS_COUNT       6'h00
`define TEC_OFS_CONTROL     6'h04
`define TEC_OFS_INTCTL      6'h08
`define TEC_OFS_FILTER      6'h0c
`define TEC_OFS_POWER       6'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TEC_CTL_MODE_HI     7
`define TEC_CTL_MODE_LO     6
`define TEC_CTL_RUN         4
`define TEC_CTL_EDGE        3
`define TEC_CTL_PSC_HI      2
`define TEC_CTL_PSC_LO      0

// ----------------------------------------
// interrupt control and power fields
// ----------------------------------------
`define TEC_INT_ENABLE      0
`define TEC_INT_FLAG        1
`define TEC_PWR_DOWN        0

// ----------------------------------------
// filter register layout
// ----------------------------------------
`define TEC_FLT_TMR_LO      0
`define TEC_FLT_IRQ_LO      4
`define TEC_FLT_USED        6

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define TEC_RST_FILTER      6'h08
`define TEC_RST_CONTROL     8'h00
`define TEC_RST_COUNT       8'h00
`define TEC_VECTOR_ADDR     8'h14
`define TEC_FILT_SAMPLES    4

`endif

// ==== rtl/tec_pkg.sv ====
// tec_pkg.sv: types shared by the timer/event counter
// assumes: tec_cfg.svh holds the register numbers; the enum encodings stand here
package tec_pkg;

   // operating mode field values
   typedef enum logic [1:0] {
      TEC_MODE_NONE  = 2'h0,
      TEC_MODE_EVENT = 2'h1,
      TEC_MODE_TIMER = 2'h2,
      TEC_MODE_PULSE = 2'h3
   } tec_mode_t;

   // pulse measurement sequencing, gray along idle-arm-measure
   typedef enum logic [1:0] {
      TEC_PW_IDLE = 2'h0,
      TEC_PW_ARM  = 2'h1,
      TEC_PW_MEAS = 2'h3
   } tec_pw_state_t;

endpackage

// ==== bench/tec_timer_assertions.sv ====
// tec_timer_assertions.sv: port-level checker for tec_timer, bound below
// assumes: one clock mclk_i, async active-low reset_n_i
`timescale 1ns/1ns
`include "tec_cfg.svh"
module tec_timer_assertions #(
   parameter int FILT_SAMPLES = `TEC_FILT_SAMPLES
) (
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic [5:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [3:0]  timer_pin_i,
   input wire logic [1:0]  ext_irq_pin_i,
   input wire logic [5:0]  pin_level_o,
   input wire logic        timer_irq_o,
   input wire logic [7:0]  timer_irq_vector_o,
   input wire logic        wake_up_o,
   input wire logic        power_down_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   logic       irq_en_reg;
   logic [7:0] stable_reg;
   logic [5:0] pins_reg;
   // ----
   // shadow of interrupt enable and pin stability
   // ----
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         irq_en_reg <= 1'b0;
      else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == `TEC_OFS_INTCTL)
         irq_en_reg <= avs_writedata_i[0];
   end
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pins_reg   <= 6'h00;
         stable_reg <= 8'h00;
      end else begin
         pins_reg   <= {ext_irq_pin_i, timer_pin_i};
         stable_reg <= (pins_reg != {ext_irq_pin_i, timer_pin_i}) ? 8'h00 : stable_reg + {7'h0, stable_reg != 8'hff};
      end
   end
   // ----
   // assertions
   // ----
   wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not accepted after one wait cycle");
   wait_back_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   vector_fixed_a: assert property (timer_irq_vector_o == `TEC_VECTOR_ADDR)
      else $error("interrupt vector wrong");
   filter_top_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == `TEC_OFS_FILTER
      |-> avs_readdata_o[7:6] == 2'b00) else $error("unused filter bits read nonzero");
   irq_enable_a: assert property (timer_irq_o |-> $past(irq_en_reg))
      else $error("interrupt without enable");
   wake_pd_a: assert property ($rose(wake_up_o) |-> $past(power_down_o))
      else $error("wake-up while not powered down");
   wake_pulse_a: assert property (wake_up_o |=> !wake_up_o)
      else $error("wake-up longer than one cycle");
   pd_clear_a: assert property (wake_up_o |-> ##[0:1] !power_down_o)
      else $error("power-down not left on wake-up");
   pin_settle_a: assert property (stable_reg >= FILT_SAMPLES + 8 |-> pin_level_o == pins_reg)
      else $error("filtered pin level does not follow stable pin");
   cover property ($rose(wake_up_o));
   cover property ($rose(timer_irq_o));
   cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind tec_timer tec_timer_assertions #(.FILT_SAMPLES(FILT_SAMPLES)) chk_u (.mclk_i, .reset_n_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
   .avs_waitrequest_o, .timer_pin_i, .ext_irq_pin_i, .pin_level_o, .timer_irq_o, .timer_irq_vector_o,
   .wake_up_o, .power_down_o);

// ==== bench/tec_pin_source.sv ====
// tec_pin_source.sv: far-side driver of the timer and interrupt pins
// assumes: tasks are called just after a rising edge of clk_i
`timescale 1ns/1ns
module tec_pin_source (
   input  wire logic       clk_i,
   output logic      [3:0] timer_pin_o,
   output logic      [1:0] ext_irq_pin_o
);
   // pins idle high through pull-ups
   initial {ext_irq_pin_o, timer_pin_o} = 6'h3f;
   task automatic hold(input logic [5:0] lvl, input int cycles);
      {ext_irq_pin_o, timer_pin_o} <= lvl;
      repeat (cycles) @(posedge clk_i);
      {ext_irq_pin_o, timer_pin_o} <= 6'h3f;
   endtask
   task automatic pulses(input int n, input int width);
      repeat (n) begin
         hold(6'h3e, width);
         repeat (width) @(posedge clk_i);
      end
   endtask
endmodule

// ==== bench/tec_timer_bench.sv ====
// tec_timer_bench.sv: self-checking bench for tec_timer
// assumes: tec_pin_source drives the pins, checker bound to the design
`timescale 1ns/1ns
module tec_timer_bench;
   logic        mclk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [5:0]  avs_address_i = 6'h00;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0]  avs_byteenable_i = 4'h1;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [3:0]  timer_pin_i;
   logic [1:0]  ext_irq_pin_i;
   logic [5:0]  pin_level_o;
   logic        timer_irq_o;
   logic [7:0]  timer_irq_vector_o;
   logic        wake_up_o;
   logic        power_down_o;
   logic [7:0]  rd;
   logic [5:0]  low_seen;
   logic        wake_seen;
   logic        irq_seen;
   int          mismatches = 0;
   int          n_compared = 0;

   always #5 mclk_i = ~mclk_i;
   tec_timer dut_u (.mclk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .timer_pin_i, .ext_irq_pin_i, .pin_level_o,
      .timer_irq_o, .timer_irq_vector_o, .wake_up_o, .power_down_o);
   tec_pin_source src_u (.clk_i(mclk_i), .timer_pin_o(timer_pin_i), .ext_irq_pin_o(ext_irq_pin_i));
   // ----
   // bus and check tasks
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // no local limit: only the watchdog ends a stuck access
   task automatic wait_acc();
      do begin
         @(posedge mclk_i);
      end while (avs_waitrequest_o !== 1'b0);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      avs_address_i   <= a;
      avs_writedata_i <= {24'h0, d};
      avs_write_i     <= 1'b1;
      wait_acc();
      avs_write_i     <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd_reg(input logic [5:0] a);
      avs_address_i <= a;
      avs_read_i    <= 1'b1;
      wait_acc();
      rd = avs_readdata_o[7:0];
      avs_read_i    <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
      rd_reg(a);
      check(rd, exp);
   endtask
   task automatic observe(input int cycles);
      low_seen  = 6'h00;
      wake_seen = 1'b0;
      irq_seen  = 1'b0;
      repeat (cycles) begin
         @(posedge mclk_i);
         low_seen  = low_seen | ~pin_level_o;
         wake_seen = wake_seen | wake_up_o;
         irq_seen  = irq_seen | timer_irq_o;
      end
   endtask
   task automatic summarize();
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial begin
      repeat (5) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      check(timer_irq_vector_o, 8'h14);
      rchk(6'h0c, 8'h08);
      rchk(6'h04, 8'h00);
      rchk(6'h3c, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(6'h0c, 8'h01 << i);
         rchk(6'h0c, (i < 6) ? 8'h01 << i : 8'h00);
      end
      avs_byteenable_i <= 4'he;
      wr(6'h0c, 8'h3f);
      avs_byteenable_i <= 4'h1;
      rchk(6'h0c, 8'h00);
      $display("test registers done");
      wr(6'h0c, 8'h02);
      repeat (12) @(posedge mclk_i);
      src_u.hold(6'h39, 2);
      observe(12);
      check({7'h0, low_seen[1]}, 8'h00);
      check({7'h0, low_seen[2]}, 8'h01);
      $display("test filter done");
      wr(6'h00, 8'hfc);
      wr(6'h04, 8'h81);
      rchk(6'h04, 8'h81);
      wr(6'h04, 8'h91);
      observe(40);
      check({7'h0, irq_seen}, 8'h00);
      rchk(6'h08, 8'h02);
      rd_reg(6'h00);
      check({7'h0, rd >= 8'hfc}, 8'h01);
      wr(6'h08, 8'h01);
      observe(20);
      check({7'h0, irq_seen}, 8'h01);
      wr(6'h04, 8'h81);
      rd_reg(6'h00);
      rchk(6'h00, rd);
      $display("test timer done");
      wr(6'h08, 8'h00);
      wr(6'h00, 8'hf0);
      wr(6'h04, 8'h80);
      wr(6'h10, 8'h01);
      check({7'h0, power_down_o}, 8'h01);
      wr(6'h04, 8'h90);
      observe(40);
      check({7'h0, wake_seen}, 8'h01);
      check({7'h0, power_down_o}, 8'h00);
      wr(6'h04, 8'h80);
      wr(6'h00, 8'hf0);
      wr(6'h08, 8'h02);
      wr(6'h10, 8'h01);
      wr(6'h04, 8'h90);
      observe(40);
      check({7'h0, wake_seen}, 8'h00);
      wr(6'h04, 8'h80);
      wr(6'h10, 8'h00);
      $display("test wake-up done");
      wr(6'h0c, 8'h01);
      wr(6'h00, 8'h00);
      wr(6'h04, 8'h40);
      wr(6'h04, 8'h50);
      wr(6'h10, 8'h01);
      src_u.pulses(5, 8);
      observe(10);
      rchk(6'h00, 8'h05);
      wr(6'h04, 8'h40);
      wr(6'h10, 8'h00);
      $display("test events done");
      wr(6'h0c, 8'h00);
      wr(6'h00, 8'h00);
      wr(6'h04, 8'hc0);
      wr(6'h04, 8'hd0);
      src_u.hold(6'h3e, 20);
      observe(10);
      rd_reg(6'h00);
      check({7'h0, rd >= 8'h13 && rd <= 8'h15}, 8'h01);
      rchk(6'h04, 8'hc0);
      wr(6'h04, 8'h80);
      wr(6'h04, 8'h90);
      rd_reg(6'h00);
      rchk(6'h00, rd + 8'h01);
      wr(6'h04, 8'h80);
      $display("test pulse done");
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      check(8'h00, 8'h01);
      summarize();
   end
endmodule
